// [bsp_port.v]
// Purpose: one buffered serial port, pin-level transmit and receive
// Assumes: external clocks far slower than mclk; pins synchronised first
// Notes: words are 16 bits MSB first; transmit words queue in an 8-word FIFO
`timescale 1ns/1ps
`include "bsp_regs.vh"
module bsp_port (
    input wire mclk,
    input wire resetn,
    input wire outputOffN,
    input wire txClockMaster,
    input wire txSyncMaster,
    input wire rxShiftClock,
    input wire rxFrameSync,
    input wire rxSerialIn,
    input wire txShiftClockIn,
    output reg txShiftClockOut,
    output reg txShiftClockOe,
    input wire txFrameSyncIn,
    output reg txFrameSyncOut,
    output reg txFrameSyncOe,
    output reg txSerialOut,
    output reg txSerialOe,
    input wire [15:0] txWord,
    input wire txValid,
    output wire txReady,
    output reg [15:0] rxWord,
    output reg rxValid,
    output reg txBusy
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_SHIFT = 2'b10;

    // edge finders; falling serves both directions, rising the transmitter only
    function rising;
        input prev;
        input cur;
        begin
            rising = cur & ~prev;
        end
    endfunction

    function falling;
        input prev;
        input cur;
        begin
            falling = prev & ~cur;
        end
    endfunction

    wire [`BSP_SYNC_WIDTH-1:0] pinSync;
    wire offNS;
    wire rxClkS;
    wire rxFsS;
    wire rxDataS;
    wire txClkS;
    wire txFsS;
    wire [15:0] fifoData;
    wire fifoValid;
    wire fifoReady;

    reg [`BSP_DIV_BITS-1:0] divCnt_q;
    reg genClk_q;
    reg txClkPrev_q;
    reg rxClkPrev_q;
    reg [1:0] txState_q;
    reg [1:0] rxState_q;
    reg [15:0] txShift_q;
    reg [15:0] rxShift_q;
    reg [`BSP_CNT_BITS-1:0] txCnt_q;
    reg [`BSP_CNT_BITS-1:0] rxCnt_q;
    reg txActive_q;
    reg popPulse_q;

    // next values for the divider, transmit and receive state registers (not edge history or pin flops), worked out in the combinational blocks
    reg [`BSP_DIV_BITS-1:0] divCnt_d;
    reg genClk_d;
    reg [1:0] txState_d;
    reg [1:0] rxState_d;
    reg [15:0] txShift_d;
    reg [15:0] rxShift_d;
    reg [`BSP_CNT_BITS-1:0] txCnt_d;
    reg [`BSP_CNT_BITS-1:0] rxCnt_d;
    reg txActive_d;
    reg popPulse_d;
    reg txSerialOut_d;
    reg txBusy_d;
    reg [15:0] rxWord_d;
    reg rxValid_d;

    wire txClk;
    wire txRise;
    wire txFall;
    wire txFsSample;
    wire rxFall;

    // all pin inputs pass two flops before any logic sees them
    bsp_sync #(
        .WIDTH(`BSP_SYNC_WIDTH)
    ) uSync (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn({outputOffN, rxShiftClock, rxFrameSync, rxSerialIn,
            txShiftClockIn, txFrameSyncIn}),
        .syncOut(pinSync)
    );

    assign offNS = pinSync[5];
    assign rxClkS = pinSync[4];
    assign rxFsS = pinSync[3];
    assign rxDataS = pinSync[2];
    assign txClkS = pinSync[1];
    assign txFsS = pinSync[0];

    // transmit words wait here; a full queue holds off the producer
    bsp_fifo #(
        .WIDTH(`BSP_WORD_BITS),
        .DEPTH(`BSP_FIFO_DEPTH),
        .AW(`BSP_FIFO_AW)
    ) uFifo (
        .mclk(mclk),
        .resetn(resetn),
        .inData(txWord),
        .inValid(txValid),
        .inReady(fifoReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(popPulse_q)
    );

    assign txReady = fifoReady;

    // shift clock source: own divider when master, pin otherwise
    assign txClk = txClockMaster ? genClk_q : txClkS; // see R3 see R4
    assign txRise = rising(txClkPrev_q, txClk);
    assign txFall = falling(txClkPrev_q, txClk); // see R9
    assign txFsSample = txSyncMaster ? txFrameSyncOut : txFsS;
    assign rxFall = falling(rxClkPrev_q, rxClkS); // see R1 see R9

    // divider next state: one toggle per half period
    always @* begin
        divCnt_d = divCnt_q + 8'h01;
        genClk_d = genClk_q;
        if (divCnt_q == `BSP_SCLK_HALF_CYC - 1) begin
            divCnt_d = 8'h00;
            genClk_d = ~genClk_q;
        end
    end

    // divider registers; the generated clock is read as data, never as a clock
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q <= 8'h00;
            genClk_q <= 1'b0;
        end else begin
            divCnt_q <= divCnt_d;
            genClk_q <= genClk_d;
        end
    end

    // pin drivers; everything floats in reset and while output-off is low
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txShiftClockOut <= 1'b0;
            txShiftClockOe <= 1'b0; // see R4
            txFrameSyncOe <= 1'b0; // see R8
            txSerialOe <= 1'b0; // see R6
        end else begin
            txShiftClockOut <= genClk_q;
            txShiftClockOe <= txClockMaster & offNS; // see R4 see R5
            txFrameSyncOe <= txSyncMaster & offNS; // see R8
            txSerialOe <= txActive_q & offNS; // see R6
        end
    end

    // master frame sync: one shift period high when a word is queued
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txFrameSyncOut <= 1'b0;
        end else if (!txSyncMaster) begin
            txFrameSyncOut <= 1'b0;
        end else if (txRise) begin
            txFrameSyncOut <= !txFrameSyncOut && fifoValid && txState_q == ST_IDLE;
        end
    end

    // transmitter next state: sync seen on a falling edge, bits change on rising edges
    always @* begin
        txState_d = txState_q;
        txShift_d = txShift_q;
        txCnt_d = txCnt_q;
        txActive_d = txActive_q;
        txSerialOut_d = txSerialOut;
        txBusy_d = txBusy;
        popPulse_d = 1'b0;
        case (txState_q)
            ST_IDLE: begin
                txActive_d = 1'b0;
                // an empty queue lets the frame pass with the line floating
                if (txFall && txFsSample && fifoValid) begin // see R7 see R9
                    txShift_d = fifoData;
                    txCnt_d = `BSP_WORD_CNT;
                    popPulse_d = 1'b1;
                    txState_d = ST_SHIFT;
                    txBusy_d = 1'b1;
                end
            end
            ST_SHIFT: begin
                if (txRise) begin // see R3
                    if (txCnt_q != 5'h00) begin
                        txSerialOut_d = txShift_q[15];
                        txShift_d = {txShift_q[14:0], 1'b0};
                        txCnt_d = txCnt_q - 5'h01;
                        txActive_d = 1'b1;
                    end else begin
                        // last bit held one full period, then release
                        txActive_d = 1'b0; // see R6
                        txState_d = ST_IDLE;
                        txBusy_d = 1'b0;
                    end
                end
            end
            default: begin
                txState_d = ST_IDLE;
            end
        endcase
    end

    // transmit registers; data, busy and the pop strobe all leave from flops
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txClkPrev_q <= 1'b0;
            txState_q <= ST_IDLE;
            txShift_q <= 16'h0000;
            txCnt_q <= 5'h00;
            txActive_q <= 1'b0;
            txSerialOut <= 1'b0;
            popPulse_q <= 1'b0;
            txBusy <= 1'b0;
        end else begin
            txClkPrev_q <= txClk;
            txState_q <= txState_d;
            txShift_q <= txShift_d;
            txCnt_q <= txCnt_d;
            txActive_q <= txActive_d;
            txSerialOut <= txSerialOut_d;
            popPulse_q <= popPulse_d;
            txBusy <= txBusy_d;
        end
    end

    // receiver next state: sync and each bit sampled on falling edges of its clock
    always @* begin
        rxState_d = rxState_q;
        rxShift_d = rxShift_q;
        rxCnt_d = rxCnt_q;
        rxWord_d = rxWord;
        rxValid_d = 1'b0;
        case (rxState_q)
            ST_IDLE: begin
                if (rxFall && rxFsS) begin // see R2
                    rxCnt_d = `BSP_WORD_CNT;
                    rxState_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (rxFall) begin // see R1
                    rxShift_d = {rxShift_q[14:0], rxDataS};
                    rxCnt_d = rxCnt_q - 5'h01;
                    if (rxCnt_q == 5'h01) begin
                        // word handed over as a one-cycle strobe, no back-pressure
                        rxWord_d = {rxShift_q[14:0], rxDataS};
                        rxValid_d = 1'b1;
                        rxState_d = ST_IDLE;
                    end
                end
            end
            default: begin
                rxState_d = ST_IDLE;
            end
        endcase
    end

    // receive registers; word and strobe leave the block from here
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rxClkPrev_q <= 1'b0;
            rxState_q <= ST_IDLE;
            rxShift_q <= 16'h0000;
            rxCnt_q <= 5'h00;
            rxWord <= 16'h0000;
            rxValid <= 1'b0;
        end else begin
            rxClkPrev_q <= rxClkS;
            rxState_q <= rxState_d;
            rxShift_q <= rxShift_d;
            rxCnt_q <= rxCnt_d;
            rxWord <= rxWord_d;
            rxValid <= rxValid_d;
        end
    end
endmodule // bsp_port

// [bsp_regs.vh]
// Purpose: constants for the buffered serial port pin block
// Assumes: mclk at 125 MHz, 16-bit serial words, MSB first
// Notes: included by bsp_port.v only
//
// How it works
// R1: the receiver shifts incoming bits on edges of the receive shift clock pin.
// R2: a frame sync pulse on the receive side starts reception of one word.
// R3: the transmitter shifts outgoing bits on edges of the transmit shift clock.
// R4: the transmit clock pin is an input or a driven output, and an input after reset (code drives it once reset ends if txClockMaster is high).
// R5: the transmit clock pin floats while the global output-off input is low.
// R6: serial transmit data floats when idle, in reset, and while output-off is low.
// R7: a frame sync pulse on the transmit side starts transmission of one word.
// R8: the transmit frame sync pin is input or output, input after reset, floats when off (code drives it once reset ends if txSyncMaster is high).
// R9: sync and data are sampled on the falling shift edge, one bit per clock period.
`ifndef BSP_REGS_VH
`define BSP_REGS_VH

`define BSP_WORD_BITS 16
`define BSP_CNT_BITS 5
`define BSP_WORD_CNT 5'h10
`define BSP_FIFO_DEPTH 8
`define BSP_FIFO_AW 3
`define BSP_SYNC_WIDTH 6

// generated shift clock, half period in ns and in mclk cycles (rounded down)
`define BSP_MCLK_NS 8
`define BSP_SCLK_HALF_NS 80
`define BSP_SCLK_HALF_CYC (`BSP_SCLK_HALF_NS / `BSP_MCLK_NS)
`define BSP_DIV_BITS 8

`endif

// [bsp_sync.v]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to mclk
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module bsp_sync #(
    parameter WIDTH = 1
) (
    input wire mclk,
    input wire resetn,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage_q;

    // metastability guard, both stages clear in reset
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage_q <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            stage_q <= asyncIn;
            syncOut <= stage_q;
        end
    end
endmodule // bsp_sync

// [bsp_fifo.v]
// Purpose: small shift-down FIFO for transmit words
// Assumes: single clock, one push and one pop per cycle at most
// Notes: head word always sits in a register, so read data is registered
`timescale 1ns/1ps
module bsp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire mclk,
    input wire resetn,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output reg inReady,
    output wire [WIDTH-1:0] outData,
    output wire outValid,
    input wire outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] count_q;
    reg [AW:0] count_d;
    wire push;
    wire pop;
    integer i;

    assign push = inValid & inReady;
    assign pop = outReady & (count_q != {(AW+1){1'b0}});
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign outData = mem[0];

    // occupancy after this cycle's push and pop
    always @* begin
        count_d = count_q;
        if (push & !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop & !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // storage shifts toward the head on a pop; no reset needed on data
    always @(posedge mclk) begin
        for (i = 0; i < DEPTH; i = i + 1) begin
            if (pop && i < DEPTH - 1) begin
                mem[i] <= mem[i+1];
            end
            if (push && (i == count_q - (pop ? 1 : 0))) begin
                mem[i] <= inData;
            end
        end
    end

    // ready is registered so it can leave the top directly
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_q <= {(AW+1){1'b0}};
            inReady <= 1'b0;
        end else begin
            count_q <= count_d;
            inReady <= (count_d < DEPTH);
        end
    end
endmodule // bsp_fifo

// [bsp_port_monitor.sv]
// Purpose: pin timing checks for bsp_port
// Assumes: bound to bsp_port, mclk domain only
// Notes: offN path gets four cycles of slack for its synchroniser
`timescale 1ns/1ps
module bsp_port_monitor (
    input wire mclk,
    input wire resetn,
    input wire outputOffN,
    input wire txClockMaster,
    input wire txSyncMaster,
    input wire txShiftClockOut,
    input wire txShiftClockOe,
    input wire txFrameSyncOut,
    input wire txFrameSyncOe,
    input wire txSerialOe,
    input wire [15:0] rxWord,
    input wire rxValid,
    input wire txBusy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // pin drive enables
    reset_float_a: assert property (disable iff (1'b0) !resetn |->
        !(txSerialOe || txShiftClockOe || txFrameSyncOe)) else $error("drive in reset");
    off_float_a: assert property (!outputOffN [*4] |->
        !(txSerialOe || txShiftClockOe || txFrameSyncOe)) else $error("drive while off");
    clk_slave_a: assert property (!txClockMaster [*2] |-> !txShiftClockOe)
        else $error("clock driven as input");
    sync_slave_a: assert property (!txSyncMaster [*2] |-> !txFrameSyncOe)
        else $error("sync driven as input");
    idle_float_a: assert property (!txBusy [*3] |-> !txSerialOe)
        else $error("data driven when idle");
    clk_drive_a: assert property (txClockMaster && outputOffN [*4] |-> txShiftClockOe)
        else $error("master clock not driven");
    // generated clock and sync timing
    clk_half_a: assert property (txClockMaster && $changed(txShiftClockOut) |=>
        $stable(txShiftClockOut) [*8] ##2 $changed(txShiftClockOut)) else $error("half period");
    sync_width_a: assert property (txSyncMaster && $rose(txFrameSyncOut) |=>
        txFrameSyncOut [*8]) else $error("sync too short");
    // receive word handoff
    rx_word_a: assert property ($changed(rxWord) |-> rxValid)
        else $error("word changed without valid");
    rx_pulse_a: assert property (rxValid |=> !rxValid [*8])
        else $error("valid too close");
endmodule // bsp_port_monitor

// [bsp_serial_partner.sv]
// Purpose: far-side serial device for bsp_port
// Assumes: one shift clock serves both directions
// Notes: clock stands still low between frames
`timescale 1ns/1ps
module bsp_serial_partner (
    input wire txLine,
    output logic sclk,
    output logic fsync,
    output logic sdata
);
    initial begin
        sclk = 1'b0;
        fsync = 1'b0;
        sdata = 1'b0;
    end
    // one frame; launch on rise, sample on fall, 160 ns per bit
    task frame(input logic [15:0] rxW, output logic [15:0] txW);
        integer i;
        begin
            for (i = 0; i < 18; i = i + 1) begin
                sclk = 1'b1;
                fsync = (i == 0);
                sdata = (i >= 1 && i <= 16) ? rxW[16 - i] : ~sdata;
                #80;
                sclk = 1'b0;
                if (i >= 1 && i <= 16) txW[16 - i] = txLine;
                #80;
            end
        end
    endtask
endmodule // bsp_serial_partner

// [bsp_port_tb_top.sv]
// Purpose: self-checking bench for bsp_port
// Assumes: partner clocks both directions in slave mode
// Notes: inputs change on falling mclk
`timescale 1ns/1ps
module bsp_port_tb_top;
    logic mclk = 1'b0;
    logic resetn = 1'b1;
    logic outputOffN = 1'b1;
    logic txClockMaster = 1'b0;
    logic txSyncMaster = 1'b0;
    logic [15:0] txWord = 16'h0;
    logic txValid = 1'b0;
    logic [15:0] rxGot = 16'h0;
    logic [15:0] got;
    int failCount = 0;
    int checked = 0;
    int cycles = 0;
    wire txShiftClockOut, txShiftClockOe, txFrameSyncOut, txFrameSyncOe;
    wire txSerialOut, txSerialOe, txReady, rxValid, txBusy, sclk, fsync, sdata;
    wire [15:0] rxWord;
    // wire levels from all drivers; data floats to z
    wire txLine = txSerialOe ? txSerialOut : 1'bz;
    wire clkPin = txShiftClockOe ? txShiftClockOut : sclk;
    wire syncPin = txFrameSyncOe ? txFrameSyncOut : fsync;
    bsp_port i_dut (.mclk(mclk), .resetn(resetn), .outputOffN(outputOffN),
        .txClockMaster(txClockMaster), .txSyncMaster(txSyncMaster), .rxShiftClock(sclk),
        .rxFrameSync(fsync), .rxSerialIn(sdata), .txShiftClockIn(clkPin),
        .txShiftClockOut(txShiftClockOut), .txShiftClockOe(txShiftClockOe),
        .txFrameSyncIn(syncPin), .txFrameSyncOut(txFrameSyncOut),
        .txFrameSyncOe(txFrameSyncOe), .txSerialOut(txSerialOut), .txSerialOe(txSerialOe),
        .txWord(txWord), .txValid(txValid), .txReady(txReady), .rxWord(rxWord),
        .rxValid(rxValid), .txBusy(txBusy));
    bsp_serial_partner i_far (.txLine(txLine), .sclk(sclk), .fsync(fsync), .sdata(sdata));
    initial forever #4 mclk = ~mclk;
    // latch words since the valid pulse is short; timeout watch
    always @(posedge mclk) begin
        if (rxValid === 1'b1) rxGot <= rxWord;
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failCount++;
            testDone;
        end
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task testDone;
        $display("checks %0d fails %0d", checked, failCount);
        if (failCount == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    function automatic logic [15:0] wd(input int i);
        wd = 16'h8001 + 16'h1357 * i[15:0];
    endfunction
    // push one word; called on a falling edge so back-to-back calls push each word once
    task push(input logic [15:0] w);
        txWord = w;
        txValid = 1'b1;
        while (txReady !== 1'b1) @(negedge mclk);
        @(negedge mclk);
    endtask
    task resetCheck;
        check({txSerialOe, txShiftClockOe, txFrameSyncOe, txReady}, 16'h0);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        check({txShiftClockOe, txFrameSyncOe, txReady}, 16'h1);
    endtask
    // fill fifo, then drain it over slow frames with stalls between
    task fillDrain;
        for (int i = 0; i < 8; i++) push(wd(i));
        txValid = 1'b0;
        check(txReady, 16'h0);
        for (int i = 0; i < 8; i++) begin
            i_far.frame(~wd(i), got);
            check(got, wd(i));
            check(rxGot, ~wd(i));
            check(txSerialOe, 16'h0);
            repeat (5) @(negedge mclk);
        end
        i_far.frame(16'h0f0f, got);
        check(got, 16'hzzzz);
        check(rxGot, 16'h0f0f);
    endtask
    // master mode under output-off, then reset in mid-frame
    task masterOff;
        int n;
        n = 0;
        outputOffN = 1'b0;
        txClockMaster = 1'b1;
        txSyncMaster = 1'b1;
        repeat (8) @(negedge mclk);
        check({txSerialOe, txShiftClockOe, txFrameSyncOe}, 16'h0);
        outputOffN = 1'b1;
        repeat (6) @(negedge mclk);
        check({txSerialOe, txShiftClockOe, txFrameSyncOe}, 16'h3);
        push(16'hc35a);
        txValid = 1'b0;
        while (txBusy !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        repeat (40) @(negedge mclk);
        check({txBusy, txSerialOe, txSerialOut}, 16'h7);
        resetn = 1'b0;
        #1;
        check({txSerialOe, txShiftClockOe, txFrameSyncOe}, 16'h0);
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        check({txSerialOe, txShiftClockOe, txFrameSyncOe, txBusy}, 16'h6);
    endtask
    initial begin
        // a real falling edge on reset clears the flops before the first clock is sampled
        #2 resetn = 1'b0;
        repeat (12) @(negedge mclk);
        resetCheck;
        fillDrain;
        masterOff;
        testDone;
    end
endmodule // bsp_port_tb_top
bind bsp_port bsp_port_monitor i_mon (.mclk(mclk), .resetn(resetn), .outputOffN(outputOffN),
    .txClockMaster(txClockMaster), .txSyncMaster(txSyncMaster),
    .txShiftClockOut(txShiftClockOut), .txShiftClockOe(txShiftClockOe),
    .txFrameSyncOut(txFrameSyncOut), .txFrameSyncOe(txFrameSyncOe),
    .txSerialOe(txSerialOe), .rxWord(rxWord), .rxValid(rxValid), .txBusy(txBusy));
